// [epc_ctrl.sv]
`timescale 1ns/1ps
module epc_ctrl
  import epc_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC
)(
  input  wire logic                      CLK_I,
  input  wire logic                      RST_N_I,
  input  wire epc_pkg::epc_req_t         REQ_I,
  input  wire logic                      REQ_VALID_I,
  output logic                           REQ_READY_O,
  output logic                           DONE_O,
  output logic                           FAIL_O,
  output logic [epc_pkg::DATA_W-1:0]     RDATA_O,
  output logic [3:0]                     PULSES_O,
  output epc_pkg::epc_pins_t             PINS_O,
  output logic [epc_pkg::DATA_W-1:0]     DQ_O,
  output logic                           DQ_OE_O,
  input  wire logic [epc_pkg::DATA_W-1:0] DQ_I
);
  import epc_pkg::*;

  // ************************************************************
  // Pin synchroniser
  // ************************************************************
  logic [DATA_W-1:0] dq_s1_r;
  logic [DATA_W-1:0] dq_s2_r;
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
    end
    else
    begin
      dq_s1_r <= DQ_I;
      dq_s2_r <= dq_s1_r;
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  typedef enum logic [2:0] {
    S_IDLE, S_SETUP, S_PULSE, S_RECOVER, S_VERIFY, S_SAMPLE
  } epc_state_t;

  localparam int TW = $clog2(PULSE_CYCLES + 1);

  epc_state_t        st_r, st_nxt;
  epc_req_t          req_r, req_nxt;
  epc_pins_t         pins_r, pins_nxt;
  logic [DATA_W-1:0] dq_r, dq_nxt;
  logic              oe_r, oe_nxt;
  logic [3:0]        cnt_r, cnt_nxt;
  logic [DATA_W-1:0] rd_r, rd_nxt;
  logic              done_r, done_nxt;
  logic              fail_r, fail_nxt;
  logic              t_start;
  logic [TW-1:0]     t_load;
  logic              t_done;

  epc_timer #(.W(TW)) u_timer (
    .CLK_I   (CLK_I),
    .RST_N_I (RST_N_I),
    .START_I (t_start),
    .LOAD_I  (t_load),
    .DONE_O  (t_done)
  );

  // Idle pins: deselected, supplies normal, so outputs float and
  // nothing can be written
  function automatic epc_pins_t idle_pins();
    epc_pins_t p;
    p = '0;
    p.chip_sel_n    = 1'b1;
    p.out_en_n      = 1'b1;
    p.write_pulse_n = 1'b1;
    return p;
  endfunction

  always_comb
  begin
    st_nxt   = st_r;
    req_nxt  = req_r;
    pins_nxt = pins_r;
    dq_nxt   = dq_r;
    oe_nxt   = oe_r;
    cnt_nxt  = cnt_r;
    rd_nxt   = rd_r;
    done_nxt = 1'b0;
    fail_nxt = 1'b0;
    t_start  = 1'b0;
    t_load   = TW'(SETTLE_CYC - 1);
    unique case (st_r)
      S_IDLE:
      begin
        if (REQ_VALID_I)
        begin
          req_nxt  = REQ_I;
          cnt_nxt  = '0;
          pins_nxt = idle_pins();
          pins_nxt.addr = REQ_I.addr;
          pins_nxt.chip_sel_n = 1'b0;
          unique case (REQ_I.cmd)
            EPC_CMD_PROG:
            begin
              pins_nxt.vpp_hi = 1'b1;
              pins_nxt.vcc_hi = 1'b1;
              dq_nxt = REQ_I.data;
              oe_nxt = 1'b1;
            end
            EPC_CMD_SIG:
            begin
              pins_nxt.id_select_hv_pin = 1'b1;
              pins_nxt.addr = {{(ADDR_W-1){1'b0}}, REQ_I.addr[0]};
              pins_nxt.out_en_n = 1'b0;
            end
            default:
            begin
              pins_nxt.out_en_n = 1'b0;
            end
          endcase
          t_start = 1'b1;
          st_nxt  = S_SETUP;
        end
      end
      S_SETUP:
      begin
        if (t_done)
        begin
          if (req_r.cmd == EPC_CMD_PROG)
          begin
            pins_nxt.write_pulse_n = 1'b0;
            cnt_nxt = cnt_r + 4'h1;
            t_load  = TW'(PULSE_CYCLES - 1);
            t_start = 1'b1;
            st_nxt  = S_PULSE;
          end
          else
            st_nxt = S_SAMPLE;
        end
      end
      S_PULSE:
      begin
        if (t_done)
        begin
          pins_nxt.write_pulse_n = 1'b1;
          oe_nxt  = 1'b0;
          t_start = 1'b1;
          st_nxt  = S_RECOVER;
        end
      end
      S_RECOVER:
      begin
        if (t_done)
        begin
          pins_nxt.out_en_n = 1'b0;
          t_start = 1'b1;
          st_nxt  = S_VERIFY;
        end
      end
      S_VERIFY:
      begin
        if (t_done)
        begin
          rd_nxt = dq_s2_r;
          pins_nxt.out_en_n = 1'b1;
          if (dq_s2_r == req_r.data)
          begin
            done_nxt = 1'b1;
            pins_nxt = idle_pins();
            st_nxt   = S_IDLE;
          end
          else if (cnt_r == 4'(MAX_PULSES))
          begin
            fail_nxt = 1'b1;
            pins_nxt = idle_pins();
            st_nxt   = S_IDLE;
          end
          else
          begin
            dq_nxt  = req_r.data;
            oe_nxt  = 1'b1;
            t_start = 1'b1;
            st_nxt  = S_SETUP;
          end
        end
      end
      S_SAMPLE:
      begin
        // Extra settle cycle lets the data pass the synchroniser
        rd_nxt   = dq_s2_r;
        done_nxt = 1'b1;
        fail_nxt = (req_r.cmd == EPC_CMD_FINAL) && (dq_s2_r != req_r.data);
        pins_nxt = idle_pins();
        st_nxt   = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      st_r   <= S_IDLE;
      req_r  <= '0;
      pins_r <= {1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, {ADDR_W{1'b0}}};
      dq_r   <= ERASED_BYTE;
      oe_r   <= 1'b0;
      cnt_r  <= '0;
      rd_r   <= '0;
      done_r <= 1'b0;
      fail_r <= 1'b0;
    end
    else
    begin
      st_r   <= st_nxt;
      req_r  <= req_nxt;
      pins_r <= pins_nxt;
      dq_r   <= dq_nxt;
      oe_r   <= oe_nxt;
      cnt_r  <= cnt_nxt;
      rd_r   <= rd_nxt;
      done_r <= done_nxt;
      fail_r <= fail_nxt;
    end
  end

  // Parallel devices share these same pin drivers
  assign PINS_O      = pins_r;
  assign DQ_O        = dq_r;
  assign DQ_OE_O     = oe_r;
  assign REQ_READY_O = (st_r == S_IDLE);
  assign DONE_O      = done_r;
  assign FAIL_O      = fail_r;
  assign RDATA_O     = rd_r;
  assign PULSES_O    = cnt_r;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  no_contention_a: assert property (oe_r |-> pins_r.out_en_n)
    else $error("Data pins driven while memory output enabled");
  prog_mode_a: assert property (!pins_r.write_pulse_n |->
      pins_r.vpp_hi && pins_r.vcc_hi && pins_r.out_en_n && !pins_r.chip_sel_n)
    else $error("Write pulse outside program mode");
  pulse_data_a: assert property (!pins_r.write_pulse_n |-> oe_r)
    else $error("Write pulse without data driven");
  pulse_stable_a: assert property (
      $fell(pins_r.write_pulse_n) |-> $stable(dq_r) && $stable(pins_r.addr))
    else $error("Pulse started as address or data moved");
  pulse_count_a: assert property (cnt_r <= 4'(MAX_PULSES))
    else $error("More than ten pulses on one byte");
  pulse_end_a: assert property ($fell(pins_r.write_pulse_n)
      |-> ##2 !pins_r.write_pulse_n)
    else $error("Program pulse too short");
  sig_addr_a: assert property (pins_r.id_select_hv_pin |->
      pins_r.addr[ADDR_W-1:1] == '0)
    else $error("Signature address bits not low");
  verify_pins_a: assert property ((st_r == S_VERIFY) &&
      pins_r.vpp_hi |-> !pins_r.out_en_n && pins_r.write_pulse_n)
    else $error("Verify read with wrong pin levels");

  prog_ok_c: cover property ((st_r == S_VERIFY) ##1 done_r);
  prog_fail_c: cover property (fail_r && req_r.cmd == EPC_CMD_PROG);
  sig_read_c: cover property (done_r && req_r.cmd == EPC_CMD_SIG);
endmodule

// [epc_mem_model.sv]
`timescale 1ns/1ps
module epc_mem_model
  import epc_pkg::*;
#(
  parameter logic [7:0] MFG_ID = 8'h5c, // Arbitrary value
  parameter logic [7:0] DEV_ID = 8'ha3  // Arbitrary value
)(
  input  wire epc_pkg::epc_pins_t P_I,
  input  wire logic [7:0]         DQ_I,
  input  wire logic [3:0]         NEED_I,
  output logic [7:0]              DQ_O
);
  logic [7:0]  mem [0:16383];
  logic [7:0]  last_q;
  logic [7:0]  pend_q;
  logic [13:0] hit_a;
  int          hits;
  logic        drv;
  initial
  begin
    foreach (mem[i])
      mem[i] = ERASED_BYTE;
    last_q = ERASED_BYTE;
    hits = 0;
    hit_a = '0;
  end
  // Selected, output enabled and not pulsing
  assign drv = !P_I.chip_sel_n && !P_I.out_en_n
               && P_I.write_pulse_n;
  // No pull-ups: a released bus shows the inverse of the last byte
  always @*
  begin
    if (drv)
    begin
      if (P_I.id_select_hv_pin)
        DQ_O = P_I.addr[0] ? DEV_ID : MFG_ID;
      else
        DQ_O = mem[P_I.addr];
      last_q = DQ_O;
    end
    else
      DQ_O = ~last_q;
  end
  always @(negedge P_I.write_pulse_n)
    pend_q = DQ_I;
  // NEED_I pulses must land before a byte takes; 15 never takes
  always @(posedge P_I.write_pulse_n)
  begin
    if (P_I.vpp_hi && P_I.vcc_hi && !P_I.chip_sel_n
        && P_I.out_en_n)
    begin
      if (P_I.addr != hit_a)
        hits = 0;
      hit_a = P_I.addr;
      hits++;
      if (hits >= NEED_I && NEED_I != 4'hf)
        mem[P_I.addr] = mem[P_I.addr] & pend_q;
    end
  end
endmodule

// [epc_pkg.sv]
package epc_pkg;
  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 14'h3fff;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ      = 25;
  localparam int PULSE_US     = 100;
  localparam int PULSE_CYC    = PULSE_US * CLK_MHZ;
  localparam int SETTLE_CYC   = 4;
  localparam int MAX_PULSES   = 10;
  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;

  typedef enum logic [2:0] {
    EPC_CMD_READ   = 3'h0,
    EPC_CMD_PROG   = 3'h1,
    EPC_CMD_SIG    = 3'h2,
    EPC_CMD_FINAL  = 3'h3
  } epc_cmd_t;

  typedef struct packed {
    epc_cmd_t            cmd;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } epc_req_t;

  typedef struct packed {
    logic                chip_sel_n;
    logic                out_en_n;
    logic                write_pulse_n;
    logic                vpp_hi;
    logic                vcc_hi;
    logic                id_select_hv_pin;
    logic [ADDR_W-1:0]   addr;
  } epc_pins_t;
endpackage

// [epc_timer.sv]
`timescale 1ns/1ps
module epc_timer
  import epc_pkg::*;
#(
  parameter int W = 12
)(
  input  wire logic         CLK_I,
  input  wire logic         RST_N_I,
  input  wire logic         START_I,
  input  wire logic [W-1:0] LOAD_I,
  output logic              DONE_O
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         run_r;
  logic         run_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    if (START_I)
    begin
      cnt_nxt = LOAD_I;
      run_nxt = 1'b1;
    end
    else if (run_r)
    begin
      if (cnt_r == '0)
        run_nxt = 1'b0;
      else
        cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
    end
  end

  // No start term: the sequencer restarts from done, which would loop
  assign DONE_O = run_r && (cnt_r == '0);
endmodule

// [test_eprom_mode_and_program_control.sv]
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("[ERR] %0t mismatch %h vs %h", $time, g, e); \
    end \
  end
module test_eprom_mode_and_program_control;
  import epc_pkg::*;
  localparam int         PULSE = 8;
  localparam logic [7:0] MFG   = 8'h5c; // Arbitrary value
  localparam logic [7:0] DEV   = 8'ha3; // Arbitrary value
  logic        clk, rst_n, valid, ready, done, fail, dq_oe;
  logic        prev_oe, supply_seen, ok, bad;
  epc_req_t    req;
  epc_pins_t   pins;
  logic [7:0]  rdata, dq_ctl, dq_mem, dq_bus, prev_d;
  logic [3:0]  pulses, need;
  logic [13:0] prev_a;
  int          failures, tests_run, cyc, low_cnt;
  assign dq_bus = dq_oe ? dq_ctl : dq_mem;
  epc_ctrl #(.PULSE_CYCLES(PULSE)) u_epc_ctrl (
    .CLK_I(clk), .RST_N_I(rst_n), .REQ_I(req), .REQ_VALID_I(valid),
    .REQ_READY_O(ready), .DONE_O(done), .FAIL_O(fail), .RDATA_O(rdata),
    .PULSES_O(pulses), .PINS_O(pins), .DQ_O(dq_ctl), .DQ_OE_O(dq_oe),
    .DQ_I(dq_bus));
  epc_mem_model #(.MFG_ID(MFG), .DEV_ID(DEV)) u_epc_mem_model (
    .P_I(pins), .DQ_I(dq_bus), .NEED_I(need), .DQ_O(dq_mem));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ******************
  // Pin monitor
  // ******************
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      failures++;
      wrap_up();
    end
    if (rst_n)
    begin
      if (!pins.write_pulse_n)
      begin
        low_cnt++;
        `CHK({pins.vpp_hi, pins.vcc_hi, pins.out_en_n, pins.chip_sel_n,
              dq_oe}, 5'b11101)
        `CHK({prev_oe, prev_a, prev_d}, {1'b1, pins.addr, dq_ctl})
      end
      else if (low_cnt != 0)
      begin
        `CHK(low_cnt, PULSE)
        low_cnt = 0;
      end
      if (!pins.out_en_n)
        `CHK(dq_oe, 1'b0)
      if (pins.id_select_hv_pin)
        `CHK(pins.addr[13:1], 13'h0000)
      supply_seen |= pins.vpp_hi | pins.vcc_hi;
      prev_oe = dq_oe;
      prev_a = pins.addr;
      prev_d = dq_ctl;
    end
  end
  // ******************
  // Tasks
  // ******************
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic run_op(input epc_cmd_t c, input logic [13:0] a,
                        input logic [7:0] d);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 50)
    begin
      tick();
      n++;
    end
    req = '{cmd: c, addr: a, data: d};
    valid = 1'b1;
    tick();
    valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && fail !== 1'b1 && n < 600)
    begin
      tick();
      n++;
    end
    ok = done;
    bad = fail;
    if (n == 600)
    begin
      failures++;
      $display("[ERR] %0t no answer from controller", $time);
    end
  endtask
  task automatic t_read();
    `CHK({pins.chip_sel_n, dq_oe}, 2'b10)
    run_op(EPC_CMD_READ, ADDR_LAST, 8'h00);
    `CHK({ok, bad, rdata}, {2'b10, ERASED_BYTE})
    $display("test read finished");
  endtask
  task automatic t_prog();
    need = 4'h3;
    run_op(EPC_CMD_PROG, 14'h1234, 8'h5a);
    `CHK({ok, bad, pulses}, {2'b10, 4'h3})
    need = 4'h1;
    run_op(EPC_CMD_PROG, 14'h0002, 8'h3c);
    `CHK({ok, bad, pulses}, {2'b10, 4'h1})
    run_op(EPC_CMD_READ, 14'h1234, 8'h00);
    `CHK(rdata, 8'h5a)
    $display("test program finished");
  endtask
  task automatic t_fail();
    need = 4'hf;
    run_op(EPC_CMD_PROG, 14'h0100, 8'h00);
    `CHK({ok, bad, pulses}, {2'b01, 4'ha})
    $display("test stubborn byte finished");
  endtask
  task automatic t_sig();
    run_op(EPC_CMD_SIG, 14'h0000, 8'h00);
    `CHK({ok, bad, rdata}, {2'b10, MFG})
    run_op(EPC_CMD_SIG, 14'h0001, 8'h00);
    `CHK({ok, bad, rdata}, {2'b10, DEV})
    $display("test signature finished");
  endtask
  task automatic t_final();
    supply_seen = 1'b0;
    run_op(EPC_CMD_FINAL, 14'h1234, 8'h5a);
    `CHK({ok, bad, supply_seen}, 3'b100)
    run_op(EPC_CMD_FINAL, 14'h0002, 8'h3d);
    `CHK({ok, bad}, 2'b11)
    $display("test final verify finished");
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    rst_n = 1'b0;
    valid = 1'b0;
    req = '0;
    need = 4'h1;
    failures = 0;
    tests_run = 0;
    cyc = 0;
    low_cnt = 0;
    prev_oe = 1'b0;
    prev_a = '0;
    prev_d = '0;
    supply_seen = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    tick();
    t_read();
    t_prog();
    t_fail();
    t_sig();
    t_final();
    wrap_up();
  end
endmodule
